// [inc/pcs_pkg.sv]
// Package of constants for the program counter and return stack unit.
package pcs_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int          PC_W        = 21;
    localparam int          SP_W        = 5;
    localparam int          STK_DEPTH   = 31;
    localparam logic [4:0]  SP_EMPTY    = 5'h00;
    localparam logic [4:0]  SP_TOP      = 5'h1f;
    localparam logic [20:0] PC_RESET    = 21'h00_0000;
    localparam logic [20:0] PC_STEP     = 21'h00_0002;
    localparam logic [20:0] ONCHIP_SIZE = 21'h02_0000;

    // ****************************************
    // Register map, byte offsets on Avalon-MM
    // ****************************************
    localparam logic [5:0] OFS_PCL     = 6'h00;
    localparam logic [5:0] OFS_LATH    = 6'h04;
    localparam logic [5:0] OFS_LATU    = 6'h08;
    localparam logic [5:0] OFS_STACK_POINTER_REG  = 6'h0c;
    localparam logic [5:0] OFS_STACK_TOP_LOW    = 6'h10;
    localparam logic [5:0] OFS_STACK_TOP_HIGH    = 6'h14;
    localparam logic [5:0] OFS_STACK_TOP_UPPER    = 6'h18;
    localparam logic [5:0] OFS_CFG     = 6'h1c;
    localparam logic [5:0] OFS_PCFULL  = 6'h20;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_FULL     = 7;
    localparam int BIT_UNF      = 6;
    localparam int BIT_CFG_EMC  = 0;
    localparam int BIT_CFG_SHFT = 1;
    localparam int BIT_CFG_OVR  = 2;
    localparam logic [2:0] CFG_RESET = 3'h4;

    // ****************************************
    // Sequencer operations from the decoder
    // ****************************************
    typedef enum logic [3:0] {
        OP_NONE, OP_FETCH, OP_JUMP, OP_CALL, OP_RET, OP_INTACK, OP_SWPUSH, OP_SWPOP, OP_LINKRET
    } pcs_op_t;

endpackage : pcs_pkg

// [verilog/pcs_core.sv]
// Program counter, return address stack and external address translation.
`timescale 1ns/1ps
// Notes on behaviour
// - Shift enabled in extended mode: external address is counter minus on-chip size.
// - Shift disabled: external address is the plain counter value.
// - Counter is 21 bits byte addressed, split low, high and upper bytes.
// - Only the low byte is directly writable; upper bytes go through latches.
// - Writing the low byte loads high and upper bytes from their latches.
// - Reading the low byte copies high and upper bytes into the latches.
// - Bit 0 is always zero; sequential fetch adds two.
// - Calls, gotos and branches load the counter directly, ignoring latches.
// - Stack holds 31 entries of 21 bits, 5-bit pointer, own storage.
// - Push on call and interrupt; pop on returns and, with link_ext_en set, link returns; latches untouched.
// - Push increments the pointer first, then writes the return address.
// - Pop reads the current entry, then decrements the pointer.
// - Reset clears the pointer; pointer zero has no entry and means empty.
// - Top-of-stack registers read and write the entry under the pointer.
// - Pointer is software readable and writable, values 0 to 31.
// - Thirty-one pushes set the full flag; only software or power-on clears it.
// - Overflow reset on: 31st push stores, sets full, resets device, pointer zero.
// - Overflow reset off: 31st push sets full, pointer 31, later pushes ignored.
// - Empty pop loads zero, sets underflow, pointer stays zero.
// - Software push increments pointer and stores current counter.
// - Software pop decrements the pointer and steps the counter by two.
// - Shift bit one enables translation, zero passes counter unchanged.
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4..0.
module pcs_core
    import pcs_pkg::*;
#(
    parameter logic [20:0] ONCHIP_BYTES = ONCHIP_SIZE
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        por,
    input  wire logic [3:0]  op,
    input  wire logic [20:0] op_target,
    input  wire logic        link_ext_en,
    output logic      [20:0] pc_q,
    output logic      [20:0] ext_addr_q,
    output logic             ext_sel_q,
    output logic             stack_reset_req,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             avs_response_err
);

    // An odd on-chip size would make the translated address misaligned; a zero one makes every address external.
    if (ONCHIP_BYTES == 21'h00_0000 || ONCHIP_BYTES[0] != 1'b0) begin : g_bad_size
        $error("pcs_core: ONCHIP_BYTES must be nonzero and even");
    end

    // ****************************************
    // Storage
    // ****************************************
    logic [20:0] stack_mem [1:STK_DEPTH];
    logic [7:0]  high_byte_latch_q;
    logic [4:0]  upper_byte_latch_q;
    logic [4:0]  sp_q;
    logic        stack_full_flag_q;
    logic        stack_underflow_flag_q;
    logic [2:0]  cfg_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        err_q;

    logic        emc_en;
    logic        shift_en;
    logic        ovr_rst_en;
    assign emc_en     = cfg_q[BIT_CFG_EMC];
    assign shift_en   = cfg_q[BIT_CFG_SHFT];
    assign ovr_rst_en = cfg_q[BIT_CFG_OVR];

    // A bus access is answered one cycle after it is presented. Register writes and the
    // latch copy of a low byte read land only at the answer edge, where the master sees
    // the transfer complete, so the side effect and the handshake agree.
    logic bus_new;
    logic bus_rd;
    logic bus_wr;
    assign bus_new         = (avs_read || avs_write) && !ack_q;
    assign bus_rd          = avs_read && ack_q;
    assign bus_wr          = avs_write && ack_q;
    assign avs_waitrequest = bus_new;
    assign avs_readdata    = rdata_q;
    assign avs_response_err = err_q;

    logic wr_pcl, wr_lath, wr_latu, wr_sp, wr_stack_top_low, wr_stack_top_high, wr_stack_top_upper, wr_cfg, rd_pcl;
    assign wr_pcl  = bus_wr && avs_address == OFS_PCL && avs_byteenable[0];
    assign wr_lath = bus_wr && avs_address == OFS_LATH && avs_byteenable[0];
    assign wr_latu = bus_wr && avs_address == OFS_LATU && avs_byteenable[0];
    assign wr_sp   = bus_wr && avs_address == OFS_STACK_POINTER_REG && avs_byteenable[0];
    assign wr_stack_top_low = bus_wr && avs_address == OFS_STACK_TOP_LOW && avs_byteenable[0];
    assign wr_stack_top_high = bus_wr && avs_address == OFS_STACK_TOP_HIGH && avs_byteenable[0];
    assign wr_stack_top_upper = bus_wr && avs_address == OFS_STACK_TOP_UPPER && avs_byteenable[0];
    assign wr_cfg  = bus_wr && avs_address == OFS_CFG && avs_byteenable[0];
    assign rd_pcl  = bus_rd && avs_address == OFS_PCL;

    // ****************************************
    // Stack operation decode
    // ****************************************
    pcs_op_t opc;
    assign opc = pcs_op_t'(op);

    logic do_push;
    logic do_pop;
    logic sw_pop;
    logic [20:0] stack_top_entry;
    logic [20:0] next_pc;
    assign next_pc = pc_q + PC_STEP;
    assign do_push = opc == OP_CALL || opc == OP_INTACK || opc == OP_SWPUSH;
    assign do_pop  = opc == OP_RET || (opc == OP_LINKRET && link_ext_en);
    assign sw_pop  = opc == OP_SWPOP;
    assign stack_top_entry     = (sp_q == SP_EMPTY) ? PC_RESET : stack_mem[sp_q];

    // Pushed value: a call stores the address of the following instruction.
    logic [20:0] push_val;
    assign push_val = (opc == OP_SWPUSH) ? pc_q : next_pc;

    logic push_ok;
    logic push_fills;
    assign push_ok    = do_push && sp_q != SP_TOP;
    assign push_fills = push_ok && sp_q == SP_TOP - 5'h01;

    assign stack_reset_req = push_fills && ovr_rst_en;

    // ****************************************
    // Stack memory
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (push_ok) begin
            stack_mem[sp_q + 5'h01] <= push_val;
        end else if (sp_q != SP_EMPTY) begin
            if (wr_stack_top_low) begin
                stack_mem[sp_q][7:0] <= {avs_writedata[7:1], 1'b0};
            end else if (wr_stack_top_high) begin
                stack_mem[sp_q][15:8] <= avs_writedata[7:0];
            end else if (wr_stack_top_upper) begin
                stack_mem[sp_q][20:16] <= avs_writedata[4:0];
            end
        end
    end

    // ****************************************
    // Stack pointer and flags
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst || stack_reset_req) begin
            sp_q <= SP_EMPTY;
        end else if (push_ok) begin
            sp_q <= sp_q + 5'h01;
        end else if ((do_pop || sw_pop) && sp_q != SP_EMPTY) begin
            sp_q <= sp_q - 5'h01;
        end else if (wr_sp) begin
            sp_q <= avs_writedata[4:0];
        end
    end

    // Flags survive ordinary resets; set beats a software clear.
    always_ff @(posedge sys_clk) begin
        if (por) begin
            stack_full_flag_q      <= 1'b0;
            stack_underflow_flag_q <= 1'b0;
        end else begin
            if (push_fills || (do_push && sp_q == SP_TOP)) begin
                stack_full_flag_q <= 1'b1;
            end else if (wr_sp && !avs_writedata[BIT_FULL]) begin
                stack_full_flag_q <= 1'b0;
            end
            if ((do_pop || sw_pop) && sp_q == SP_EMPTY) begin
                stack_underflow_flag_q <= 1'b1;
            end else if (wr_sp && !avs_writedata[BIT_UNF]) begin
                stack_underflow_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Program counter
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst || stack_reset_req) begin
            pc_q <= PC_RESET;
        end else if (do_push && opc != OP_SWPUSH) begin
            pc_q <= {op_target[20:1], 1'b0};
        end else if (opc == OP_JUMP) begin
            pc_q <= {op_target[20:1], 1'b0};
        end else if (do_pop) begin
            pc_q <= {stack_top_entry[20:1], 1'b0};
        end else if (opc == OP_FETCH || opc == OP_SWPUSH || sw_pop) begin
            pc_q <= next_pc;
        end else if (wr_pcl) begin
            pc_q <= {upper_byte_latch_q, high_byte_latch_q, avs_writedata[7:1], 1'b0};
        end
    end

    // Latches are written only by software or by a low byte read.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            high_byte_latch_q  <= 8'h00;
            upper_byte_latch_q <= 5'h00;
        end else if (rd_pcl) begin
            high_byte_latch_q  <= pc_q[15:8];
            upper_byte_latch_q <= pc_q[20:16];
        end else begin
            if (wr_lath) begin
                high_byte_latch_q <= avs_writedata[7:0];
            end
            if (wr_latu) begin
                upper_byte_latch_q <= avs_writedata[4:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= avs_writedata[2:0];
        end
    end

    // ****************************************
    // External address translation
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_addr_q <= PC_RESET;
            ext_sel_q  <= 1'b0;
        end else begin
            ext_sel_q <= emc_en && pc_q >= ONCHIP_BYTES;
            if (emc_en && shift_en && pc_q >= ONCHIP_BYTES) begin
                ext_addr_q <= pc_q - ONCHIP_BYTES;
            end else begin
                ext_addr_q <= pc_q;
            end
        end
    end

    // ****************************************
    // Bus slave read side
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            ack_q <= bus_new;
            err_q <= 1'b0;
            if (bus_new) begin
                rdata_q <= 32'h0000_0000;
                if (avs_address == OFS_PCL) begin
                    rdata_q[7:0] <= pc_q[7:0];
                end else if (avs_address == OFS_LATH) begin
                    rdata_q[7:0] <= high_byte_latch_q;
                end else if (avs_address == OFS_LATU) begin
                    rdata_q[4:0] <= upper_byte_latch_q;
                end else if (avs_address == OFS_STACK_POINTER_REG) begin
                    rdata_q[7:0] <= {stack_full_flag_q, stack_underflow_flag_q, 1'b0, sp_q};
                end else if (avs_address == OFS_STACK_TOP_LOW) begin
                    rdata_q[7:0] <= stack_top_entry[7:0];
                end else if (avs_address == OFS_STACK_TOP_HIGH) begin
                    rdata_q[7:0] <= stack_top_entry[15:8];
                end else if (avs_address == OFS_STACK_TOP_UPPER) begin
                    rdata_q[4:0] <= stack_top_entry[20:16];
                end else if (avs_address == OFS_CFG) begin
                    rdata_q[2:0] <= cfg_q;
                end else if (avs_address == OFS_PCFULL) begin
                    rdata_q[20:0] <= pc_q;
                end else begin
                    err_q <= 1'b1;
                end
            end
        end
    end

endmodule : pcs_core

// [verification/pcs_core_properties.sv]
// Concurrent checks on the ports of the sequencer core.
`timescale 1ns/1ps
module pcs_core_checker
    import pcs_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [3:0]  op,
    input wire logic [20:0] op_target,
    input wire logic [20:0] pc_q,
    input wire logic        stack_reset_req,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        avs_response_err
);
    // ****************************************
    // Counter and bus relations
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_pc_even_always: assert property (pc_q[0] == 1'b0)
        else $error("Counter bit zero is set");
    a_fetch_adds_two: assert property (op == OP_FETCH |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("Fetch did not advance the counter by two");
    a_jump_takes_target: assert property (op == OP_JUMP
        |=> pc_q == ($past(op_target) & 21'h1f_fffe))
        else $error("Jump did not load the target");
    a_call_takes_target: assert property ((op == OP_CALL || op == OP_INTACK)
        && !stack_reset_req |=> pc_q == ($past(op_target) & 21'h1f_fffe))
        else $error("Call did not load the target");
    a_swop_steps_pc: assert property ((op == OP_SWPUSH || op == OP_SWPOP)
        && !stack_reset_req |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("Software stack operation disturbed the counter");
    a_idle_pc_holds: assert property (op == OP_NONE && !avs_write |=> $stable(pc_q))
        else $error("Counter changed without cause");
    a_bus_answers_next: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("Bus access not answered in the second cycle");
    a_err_in_answer: assert property (avs_response_err
        |-> !avs_waitrequest && (avs_read || avs_write))
        else $error("Error response outside an answer cycle");
    a_reset_pc_zero: assert property (disable iff (1'b0) rst |=> pc_q == PC_RESET)
        else $error("Counter not cleared by reset");
endmodule : pcs_core_checker

bind pcs_core pcs_core_checker u_checker (.sys_clk(sys_clk), .rst(rst), .op(op),
    .op_target(op_target), .pc_q(pc_q), .stack_reset_req(stack_reset_req),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err));

// [verification/pcs_decoder_model.sv]
// Decoder and reset controller model facing the sequencer core.
`timescale 1ns/1ps
module pcs_decoder_model
    import pcs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        bench_rst,
    input  wire logic        cmd_valid,
    input  wire logic [3:0]  cmd_op,
    input  wire logic [20:0] cmd_target,
    input  wire logic        stack_reset_req,
    output logic             rst = 1'b1,
    output logic      [3:0]  op,
    output logic      [20:0] op_target
);
    // Idle target lines toggle so a stale value is never mistaken for a real one.
    always @(posedge sys_clk) begin
        op <= cmd_valid ? cmd_op : OP_NONE;
        op_target <= bench_rst ? 21'h00_0000 : (cmd_valid ? cmd_target : ~op_target);
        rst <= bench_rst | stack_reset_req;
    end
endmodule : pcs_decoder_model

// [verification/test_program_counter_return_stack.sv]
// Self-checking bench for the program counter and return stack core.
`timescale 1ns/1ps
module test_program_counter_return_stack
    import pcs_pkg::*;
();
    logic        sys_clk, bench_rst, por, rst, cmd_valid, link_ext_en, e;
    logic        reset_seen = 1'b0;
    logic        avs_read, avs_write, avs_waitrequest, avs_response_err, stack_reset_req, ext_sel_q;
    logic [3:0]  cmd_op, op;
    logic [4:0]  sp_m;
    logic [5:0]  avs_address;
    logic [20:0] cmd_target, op_target, pc_q, ext_addr_q, pc_m, t, stk[32];
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [31:0] seed = 32'hf8bc_1331;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          i;

    pcs_decoder_model u_dec (.sys_clk(sys_clk), .bench_rst(bench_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_target(cmd_target), .stack_reset_req(stack_reset_req), .rst(rst),
        .op(op), .op_target(op_target));
    pcs_core DUT (.sys_clk(sys_clk), .rst(rst), .por(por), .op(op), .op_target(op_target),
        .link_ext_en(link_ext_en), .pc_q(pc_q), .ext_addr_q(ext_addr_q), .ext_sel_q(ext_sel_q),
        .stack_reset_req(stack_reset_req), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response_err(avs_response_err));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (stack_reset_req === 1'b1) reset_seen <= 1'b1;

    // ****************************************
    // Expectations and checking
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [20:0] ext_exp(input logic shft, input logic [20:0] a);
        return (shft && a >= ONCHIP_SIZE) ? a - ONCHIP_SIZE : a;
    endfunction : ext_exp
    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ****************************************
    // Bus and decoder drivers
    // ****************************************
    // Waitrequest and read data are both taken at the rising edge that completes the access.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            mismatches++;
            results();
        end
        q = avs_readdata;
        e = avs_response_err;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] x);
        bus(1'b0, a, 8'h00);
        check(q, x);
    endtask : rd
    task automatic issue(input pcs_op_t o, input logic [20:0] tg);
        tg[0] = 1'b0;
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_target <= tg;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        case (o)
            OP_JUMP: pc_m = tg;
            OP_CALL, OP_INTACK: begin
                sp_m = sp_m + 5'h1;
                stk[sp_m] = pc_m + PC_STEP;
                pc_m = tg;
            end
            OP_RET, OP_LINKRET: begin
                pc_m = stk[sp_m];
                sp_m = sp_m - 5'h1;
            end
            default: pc_m = pc_m + PC_STEP;
        endcase
    endtask : issue

    initial begin
        {bench_rst, por} = 2'b11;
        {cmd_valid, avs_read, avs_write, cmd_op, cmd_target, avs_address} = '0;
        {avs_writedata, pc_m, sp_m, link_ext_en} = '0;
        stk = '{default: '0};
        repeat (6) @(posedge sys_clk);
        bench_rst <= 1'b0;
        por <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(OFS_STACK_POINTER_REG, 32'h0000_0000);
        rd(OFS_CFG, {29'h0, CFG_RESET});
        bus(1'b0, 6'h24, 8'h00);
        check({q[30:0], e}, 32'h0000_0001);
        link_ext_en <= 1'b1;
        seed = xs(seed);
        issue(OP_JUMP, seed[20:0]);
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            issue(i[0] ? OP_INTACK : OP_CALL, seed[20:0]);
            rd(OFS_STACK_TOP_LOW, {24'h0, stk[sp_m][7:0]});
            rd(OFS_STACK_TOP_HIGH, {24'h0, stk[sp_m][15:8]});
            rd(OFS_STACK_TOP_UPPER, {27'h0, stk[sp_m][20:16]});
        end
        link_ext_en <= 1'b0;
        issue(OP_LINKRET, 21'h0);
        sp_m = 5'h6;
        rd(OFS_STACK_POINTER_REG, 32'h0000_0006);
        link_ext_en <= 1'b1;
        for (i = 0; i < 6; i++) begin
            issue(i[0] ? OP_RET : OP_LINKRET, 21'h0);
            rd(OFS_PCFULL, {11'h0, pc_m});
        end
        issue(OP_RET, 21'h0);
        sp_m = 5'h0;
        rd(OFS_PCFULL, 32'h0000_0000);
        rd(OFS_STACK_POINTER_REG, 32'h0000_0040);
        wr(OFS_STACK_POINTER_REG, 8'h00);
        rd(OFS_STACK_POINTER_REG, 32'h0000_0000);
        seed = xs(seed);
        issue(OP_JUMP, seed[20:0]);
        issue(OP_FETCH, 21'h0);
        stk[1] = pc_m;
        issue(OP_SWPUSH, 21'h0);
        rd(OFS_STACK_POINTER_REG, 32'h0000_0001);
        rd(OFS_STACK_TOP_LOW, {24'h0, stk[1][7:0]});
        issue(OP_SWPOP, 21'h0);
        rd(OFS_STACK_POINTER_REG, 32'h0000_0000);
        rd(OFS_PCFULL, {11'h0, pc_m});
        rd(OFS_PCL, {24'h0, pc_m[7:0]});
        rd(OFS_LATH, {24'h0, pc_m[15:8]});
        rd(OFS_LATU, {27'h0, pc_m[20:16]});
        seed = xs(seed);
        wr(OFS_LATH, seed[7:0]);
        wr(OFS_LATU, {3'h0, seed[12:8]});
        wr(OFS_PCL, seed[23:16]);
        pc_m = {seed[12:8], seed[7:0], seed[23:17], 1'b0};
        rd(OFS_PCFULL, {11'h0, pc_m});
        issue(OP_CALL, 21'h0);
        rd(OFS_LATH, {24'h0, seed[7:0]});
        wr(OFS_CFG, 8'h00);
        wr(OFS_STACK_POINTER_REG, 8'h1e);
        rd(OFS_STACK_POINTER_REG, 32'h0000_001e);
        sp_m = 5'h1e;
        issue(OP_CALL, 21'h100);
        t = stk[31];
        rd(OFS_STACK_POINTER_REG, 32'h0000_009f);
        issue(OP_CALL, 21'h200);
        rd(OFS_STACK_POINTER_REG, 32'h0000_009f);
        rd(OFS_STACK_TOP_LOW, {24'h0, t[7:0]});
        check({31'h0, reset_seen}, 32'h0000_0000);
        wr(OFS_CFG, 8'h04);
        wr(OFS_STACK_POINTER_REG, 8'h1e);
        issue(OP_CALL, 21'h300);
        check({31'h0, reset_seen}, 32'h0000_0001);
        rd(OFS_STACK_POINTER_REG, 32'h0000_0080);
        issue(OP_CALL, 21'h400);
        seed = xs(seed);
        wr(OFS_STACK_TOP_LOW, {seed[7:1], 1'b0});
        wr(OFS_STACK_TOP_HIGH, seed[15:8]);
        wr(OFS_STACK_TOP_UPPER, {3'h0, seed[20:16]});
        issue(OP_RET, 21'h0);
        rd(OFS_PCFULL, {11'h0, seed[20:1], 1'b0});
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            t = i[2] ? (ONCHIP_SIZE | seed[20:0]) : {5'h0, seed[15:0]};
            t = (i == 7) ? ONCHIP_SIZE : {t[20:1], 1'b0};
            wr(OFS_CFG, {6'h0, i[1:0]});
            issue(OP_JUMP, t);
            check({31'h0, ext_sel_q}, {31'h0, i[0] && t >= ONCHIP_SIZE});
            if (i[0]) check({11'h0, ext_addr_q}, {11'h0, ext_exp(i[1], t)});
        end
        results();
    end
endmodule : test_program_counter_return_stack
